/* File: hdl/sdc_top.sv */
// Serial DMA control: registers, byte sequencer, chip select, gaps and port event flag
//
// The address-and-strobe port was left to the implementer.
`include "sdc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module sdc_top (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire sdc_pkg::sdc_bus_s reg_bus_i,
    output logic [7:0] reg_rdata_o,
    input wire logic spi_master_i,
    input wire logic [1:0] clk_div_i,
    output logic sp_tx_valid_o,
    output logic [7:0] sp_tx_data_o,
    input wire logic sp_byte_done_i,
    input wire logic [7:0] sp_rx_data_i,
    output var sdc_pkg::sdc_mem_s mem_req_o,
    input wire logic [7:0] mem_rdata_i,
    output logic auto_chip_select_out_n_o,
    output logic port_event_flag_o,
    output logic transfer_active_o
);
    import sdc_pkg::*;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction : hit

    sdc_state_e state_ff;
    sdc_state_e nxt_state;
    logic [7:0] mode_ff;
    logic [7:0] nxt_mode;
    logic [7:0] gwm_ff;
    logic [7:0] nxt_gwm;
    logic [9:0] cnt_ff;
    logic [9:0] nxt_cnt;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] txd_ff;
    logic [7:0] nxt_txd;
    logic tx_stb_ff;
    logic nxt_tx_stb;
    logic [7:0] rxd_ff;
    logic [7:0] nxt_rxd;
    logic cs_n_ff;
    logic nxt_cs_n;
    logic [1:0] grp_ff;
    logic [1:0] nxt_grp;
    logic armed_ff;
    logic nxt_armed;
    logic evt_ff;
    logic nxt_evt;
    logic tmo_ff;
    logic nxt_tmo;

    logic wr_mode;
    logic wr_gwm;
    logic wr_status;
    logic active;
    logic [1:0] csc;
    logic [1:0] dir;
    logic gis;
    logic tx_mode;
    logic rx_mode;
    logic byte_ok;
    logic last_byte;
    logic last_in_grp;
    logic [1:0] grp_top;
    logic [10:0] remaining;
    logic [10:0] wm_level;
    logic [11:0] min_gap;
    logic [11:0] gap_len;
    logic gap_load;
    logic gap_expire;
    logic tmo_load;
    logic tmo_expire;
    logic timers_clear;
    logic tx_step;
    logic rx_step;
    logic [11:0] tx_ptr;
    logic [11:0] rx_ptr;

    assign wr_mode = reg_bus_i.wr && hit(reg_bus_i.addr, `SDC_OFS_MODE);
    assign wr_gwm = reg_bus_i.wr && hit(reg_bus_i.addr, `SDC_OFS_GAP_WM);
    assign wr_status = reg_bus_i.wr && hit(reg_bus_i.addr, `SDC_OFS_STATUS);

    assign active = mode_ff[`SDC_BIT_ACTIVE];
    assign csc = mode_ff[`SDC_POS_CSC +: 2];
    assign dir = mode_ff[`SDC_POS_DIR +: 2];
    assign gis = mode_ff[`SDC_BIT_GIS];
    // Code 11 is undefined; it is run as full duplex
    assign tx_mode = (dir != `SDC_DIR_RX);
    assign rx_mode = (dir != `SDC_DIR_TX);

    // A byte only counts when it completes while the session is still on
    assign byte_ok = (state_ff == ST_STORE) && active;
    assign last_byte = (cnt_ff == 10'h000);

    always_comb begin
        case (csc)
            `SDC_CSC_4: grp_top = 2'd3;
            `SDC_CSC_2: grp_top = 2'd1;
            default: grp_top = 2'd0;
        endcase
    end
    assign last_in_grp = (grp_ff == grp_top);

    assign remaining = {1'b0, cnt_ff} + 11'h001;
    assign wm_level = sdc_wm_bytes(gwm_ff[`SDC_POS_WM +: 4]);

    always_comb begin
        case (clk_div_i)
            2'b00: min_gap = `SDC_MIN_GAP_FAST;
            2'b01: min_gap = `SDC_MIN_GAP_MID;
            default: min_gap = `SDC_MIN_GAP_SLOW;
        endcase
    end

    // Gap interrupt mode trims the added delay to a single cycle
    assign gap_len = min_gap + (gis ? `SDC_GIS_EXTRA
                                    : sdc_gap_cycles(gwm_ff[`SDC_POS_GAP +: 4]));
    assign gap_load = byte_ok && !last_byte && spi_master_i;
    assign tmo_load = byte_ok && !last_byte && gis;
    assign timers_clear = (state_ff == ST_IDLE);

    assign tx_step = byte_ok && tx_mode && mode_ff[`SDC_BIT_TX_STEP];
    assign rx_step = byte_ok && rx_mode && mode_ff[`SDC_BIT_RX_STEP];

    sdc_ptr u_tx_ptr (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .wr_lo_i(reg_bus_i.wr && hit(reg_bus_i.addr, `SDC_OFS_TX_LO)),
        .wr_hi_i(reg_bus_i.wr && hit(reg_bus_i.addr, `SDC_OFS_TX_HI)),
        .wdata_i(reg_bus_i.wdata),
        .step_i(tx_step),
        .ptr_o(tx_ptr)
    );

    sdc_ptr u_rx_ptr (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .wr_lo_i(reg_bus_i.wr && hit(reg_bus_i.addr, `SDC_OFS_RX_LO)),
        .wr_hi_i(reg_bus_i.wr && hit(reg_bus_i.addr, `SDC_OFS_RX_HI)),
        .wdata_i(reg_bus_i.wdata),
        .step_i(rx_step),
        .ptr_o(rx_ptr)
    );

    sdc_gap_timer #(.W(12)) u_gap_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(gap_load),
        .len_i(gap_len),
        .clear_i(timers_clear),
        .expire_o(gap_expire)
    );

    // Runs in either role once gap interrupt select is set
    sdc_gap_timer #(.W(12)) u_tmo_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(tmo_load),
        .len_i(sdc_gap_cycles(gwm_ff[`SDC_POS_GAP +: 4])),
        .clear_i(timers_clear),
        .expire_o(tmo_expire)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        nxt_gwm = gwm_ff;
        nxt_cnt = cnt_ff;
        nxt_txd = txd_ff;
        nxt_tx_stb = 1'b0;
        nxt_rxd = rxd_ff;
        nxt_cs_n = cs_n_ff;
        nxt_grp = grp_ff;
        nxt_armed = armed_ff;
        nxt_evt = evt_ff;
        nxt_tmo = tmo_ff;

        if (wr_gwm) begin
            nxt_gwm = reg_bus_i.wdata;
            nxt_armed = 1'b1;
        end
        if (wr_mode) begin
            nxt_mode = reg_bus_i.wdata;
            // A one is refused while a cancelled byte is still draining
            nxt_mode[`SDC_BIT_ACTIVE] = reg_bus_i.wdata[`SDC_BIT_ACTIVE]
                                        && (state_ff == ST_IDLE || active);
        end
        if (nxt_mode[`SDC_POS_CSC +: 2] != `SDC_CSC_OFF) begin
            nxt_mode[`SDC_BIT_GIS] = 1'b0;
        end
        if (reg_bus_i.wr && hit(reg_bus_i.addr, `SDC_OFS_CNT_LO)) begin
            nxt_cnt[7:0] = reg_bus_i.wdata;
        end
        if (reg_bus_i.wr && hit(reg_bus_i.addr, `SDC_OFS_CNT_HI)) begin
            nxt_cnt[9:8] = reg_bus_i.wdata[1:0];
        end
        if (wr_status) begin
            nxt_evt = evt_ff & ~reg_bus_i.wdata[`SDC_BIT_EVT];
            nxt_tmo = tmo_ff & ~reg_bus_i.wdata[`SDC_BIT_TMO];
        end

        case (state_ff)
            ST_IDLE: begin
                nxt_cs_n = 1'b1;
                if (wr_mode && reg_bus_i.wdata[`SDC_BIT_ACTIVE]) begin
                    nxt_state = ST_FETCH;
                    nxt_armed = 1'b1;
                    nxt_grp = 2'd0;
                end
            end
            ST_FETCH: begin
                nxt_state = active ? ST_LOAD : ST_IDLE;
            end
            ST_LOAD: begin
                if (!active) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_txd = tx_mode ? mem_rdata_i : `SDC_IDLE_FILL;
                    nxt_tx_stb = 1'b1;
                    if (spi_master_i && csc != `SDC_CSC_OFF) begin
                        nxt_cs_n = 1'b0;
                    end
                    nxt_state = ST_XFER;
                end
            end
            ST_XFER: begin
                // The byte on the wire always runs to its end
                if (sp_byte_done_i) begin
                    nxt_rxd = sp_rx_data_i;
                    nxt_state = ST_STORE;
                end
            end
            ST_STORE: begin
                if (!active) begin
                    nxt_cs_n = 1'b1;
                    nxt_state = ST_IDLE;
                end else if (last_byte) begin
                    nxt_mode[`SDC_BIT_ACTIVE] = 1'b0;
                    nxt_cs_n = 1'b1;
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_cnt = cnt_ff - 10'h001;
                    if (last_in_grp) begin
                        nxt_cs_n = 1'b1;
                        nxt_grp = 2'd0;
                    end else begin
                        nxt_grp = grp_ff + 2'd1;
                    end
                    nxt_state = spi_master_i ? ST_GAP : ST_FETCH;
                end
            end
            ST_GAP: begin
                if (!active) begin
                    nxt_cs_n = 1'b1;
                    nxt_state = ST_IDLE;
                end else if (gap_expire) begin
                    nxt_state = ST_FETCH;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase

        // Sets come last so that they win over a clear in the same cycle
        if (byte_ok && last_byte) begin
            nxt_evt = 1'b1;
        end
        if (state_ff != ST_IDLE && active && armed_ff && wm_level != 11'h000
            && remaining <= wm_level) begin
            nxt_evt = 1'b1;
            nxt_armed = 1'b0;
        end
        if (tmo_expire && gis) begin
            nxt_tmo = 1'b1;
            nxt_evt = 1'b1;
        end
    end

    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_bus_i.rd) begin
            case (reg_bus_i.addr)
                `SDC_OFS_MODE: nxt_rdata = mode_ff;
                `SDC_OFS_GAP_WM: nxt_rdata = gwm_ff;
                `SDC_OFS_CNT_LO: nxt_rdata = cnt_ff[7:0];
                `SDC_OFS_CNT_HI: nxt_rdata = {6'h00, cnt_ff[9:8]};
                `SDC_OFS_TX_LO: nxt_rdata = tx_ptr[7:0];
                `SDC_OFS_TX_HI: nxt_rdata = {4'h0, tx_ptr[11:8]};
                `SDC_OFS_RX_LO: nxt_rdata = rx_ptr[7:0];
                `SDC_OFS_RX_HI: nxt_rdata = {4'h0, rx_ptr[11:8]};
                `SDC_OFS_STATUS: nxt_rdata = {6'h00, tmo_ff, evt_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= ST_IDLE;
            mode_ff <= `SDC_RST_BYTE;
            gwm_ff <= `SDC_RST_BYTE;
            cnt_ff <= `SDC_RST_CNT;
            rdata_ff <= 8'h00;
            txd_ff <= 8'h00;
            tx_stb_ff <= 1'b0;
            rxd_ff <= 8'h00;
            cs_n_ff <= 1'b1;
            grp_ff <= 2'd0;
            armed_ff <= 1'b0;
            evt_ff <= 1'b0;
            tmo_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            gwm_ff <= nxt_gwm;
            cnt_ff <= nxt_cnt;
            rdata_ff <= nxt_rdata;
            txd_ff <= nxt_txd;
            tx_stb_ff <= nxt_tx_stb;
            rxd_ff <= nxt_rxd;
            cs_n_ff <= nxt_cs_n;
            grp_ff <= nxt_grp;
            armed_ff <= nxt_armed;
            evt_ff <= nxt_evt;
            tmo_ff <= nxt_tmo;
        end
    end

    // One read per byte to send, one write per byte received
    assign mem_req_o.rd = (state_ff == ST_FETCH) && active && tx_mode;
    assign mem_req_o.wr = byte_ok && rx_mode;
    assign mem_req_o.addr = (state_ff == ST_FETCH) ? tx_ptr : rx_ptr;
    assign mem_req_o.wdata = rxd_ff;

    assign reg_rdata_o = rdata_ff;
    assign sp_tx_valid_o = tx_stb_ff;
    assign sp_tx_data_o = txd_ff;
    assign auto_chip_select_out_n_o = cs_n_ff;
    assign port_event_flag_o = evt_ff;
    assign transfer_active_o = active;
endmodule : sdc_top
`default_nettype wire

/* File: hdl/sdc_defs.svh */
// Register offsets, field positions, reset values and timing counts of the serial DMA control
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH

`define SDC_OFS_CNT_LO 12'hf84
`define SDC_OFS_CNT_HI 12'hf85
`define SDC_OFS_GAP_WM 12'hf86
`define SDC_OFS_MODE 12'hf88
`define SDC_OFS_TX_LO 12'hf8a
`define SDC_OFS_TX_HI 12'hf8b
`define SDC_OFS_RX_LO 12'hf8c
`define SDC_OFS_RX_HI 12'hf8d
`define SDC_OFS_STATUS 12'hf8e

`define SDC_RST_BYTE 8'h00
`define SDC_RST_CNT 10'h000

`define SDC_BIT_ACTIVE 0
`define SDC_BIT_GIS 1
`define SDC_POS_DIR 2
`define SDC_BIT_RX_STEP 4
`define SDC_BIT_TX_STEP 5
`define SDC_POS_CSC 6
`define SDC_POS_GAP 4
`define SDC_POS_WM 0
`define SDC_BIT_EVT 0
`define SDC_BIT_TMO 1

`define SDC_DIR_FULL 2'b10
`define SDC_DIR_TX 2'b01
`define SDC_DIR_RX 2'b00
`define SDC_CSC_OFF 2'b00
`define SDC_CSC_4 2'b11
`define SDC_CSC_2 2'b01

`define SDC_MIN_GAP_FAST 12'd8
`define SDC_MIN_GAP_MID 12'd9
`define SDC_MIN_GAP_SLOW 12'd15
`define SDC_GIS_EXTRA 12'd1
`define SDC_WM_ODD 11'd67
`define SDC_IDLE_FILL 8'hff

`endif

/* File: hdl/sdc_pkg.sv */
// Types and decode functions shared by the serial DMA control files
`include "sdc_defs.svh"
package sdc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_LOAD  = 3'b010,
        ST_XFER  = 3'b011,
        ST_STORE = 3'b100,
        ST_GAP   = 3'b101
    } sdc_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } sdc_bus_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } sdc_mem_s;

    // Gap field to cycles: 1..128 as powers of two, 256..896 by 128, then 1024, 2048
    function automatic logic [11:0] sdc_gap_cycles(input logic [3:0] f);
        logic [11:0] r;
        r = 12'h000;
        if (!f[3]) begin
            r = 12'h001 << f[2:0];
        end else if (f[3:1] == 3'b111) begin
            r = f[0] ? 12'h800 : 12'h400;
        end else begin
            r = {2'b00, 3'(f[2:0] + 3'd2), 7'h00};
        end
        return r;
    endfunction : sdc_gap_cycles

    // Watermark field to bytes remaining; zero means completion only
    function automatic logic [10:0] sdc_wm_bytes(input logic [3:0] f);
        logic [10:0] r;
        r = 11'h000;
        if (f == 4'h0) begin
            r = 11'h000;
        end else if (f == 4'h7) begin
            r = `SDC_WM_ODD;
        end else if (!f[3]) begin
            r = 11'h001 << (f[2:0] - 3'd1);
        end else begin
            r = {1'b0, 4'(f[2:0] + 4'd2), 6'h00};
        end
        return r;
    endfunction : sdc_wm_bytes

endpackage : sdc_pkg

/* File: hdl/sdc_gap_timer.sv */
// Down-counter that pulses once a loaded number of cycles has passed
`timescale 1ns/100ps
`default_nettype none
module sdc_gap_timer #(
    parameter int W = 12
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic load_i,
    input wire logic [W-1:0] len_i,
    input wire logic clear_i,
    output logic expire_o
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (clear_i) begin
            nxt_cnt = '0;
        end else if (load_i) begin
            nxt_cnt = len_i;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - W'(1);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign expire_o = (cnt_ff == W'(1));
endmodule : sdc_gap_timer
`default_nettype wire

/* File: hdl/sdc_ptr.sv */
// Twelve-bit SRAM pointer loaded as a byte pair that can step by one
`timescale 1ns/100ps
`default_nettype none
module sdc_ptr (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_lo_i,
    input wire logic wr_hi_i,
    input wire logic [7:0] wdata_i,
    input wire logic step_i,
    output logic [11:0] ptr_o
);
    logic [11:0] ptr_ff;
    logic [11:0] nxt_ptr;

    always_comb begin
        nxt_ptr = ptr_ff;
        if (step_i) begin
            nxt_ptr = ptr_ff + 12'h001;
        end else begin
            if (wr_lo_i) begin
                nxt_ptr[7:0] = wdata_i;
            end
            if (wr_hi_i) begin
                nxt_ptr[11:8] = wdata_i[3:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_ff <= 12'h000;
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    assign ptr_o = ptr_ff;
endmodule : sdc_ptr
`default_nettype wire

/* File: verif/sdc_monitor.sv */
// Concurrent checks on the serial DMA control ports
`timescale 1ns/100ps
`default_nettype none
module sdc_monitor (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire sdc_pkg::sdc_bus_s reg_bus_i,
    input wire logic spi_master_i,
    input wire logic sp_tx_valid_o,
    input wire logic [7:0] sp_tx_data_o,
    input wire logic sp_byte_done_i,
    input wire logic [7:0] sp_rx_data_i,
    input wire sdc_pkg::sdc_mem_s mem_req_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic auto_chip_select_out_n_o,
    input wire logic port_event_flag_o,
    input wire logic transfer_active_o
);
    import sdc_pkg::*;
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_stop;
        reg_bus_i.wr && reg_bus_i.addr == 12'hf88 && !reg_bus_i.wdata[0] |=> !transfer_active_o;
    endproperty
    a_stop: assert property (p_stop) else $error("stop write ignored");
    property p_strobe;
        sp_tx_valid_o || mem_req_o.rd |-> transfer_active_o;
    endproperty
    a_strobe: assert property (p_strobe) else $error("traffic while idle");
    property p_fetch;
        mem_req_o.rd ##1 transfer_active_o |=> sp_tx_valid_o && sp_tx_data_o == $past(mem_rdata_i);
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetched byte not sent");
    property p_fill;
        sp_tx_valid_o && !$past(mem_req_o.rd, 2) |-> sp_tx_data_o == 8'hff;
    endproperty
    a_fill: assert property (p_fill) else $error("receive fill wrong");
    property p_store;
        mem_req_o.wr |-> $past(sp_byte_done_i) && mem_req_o.wdata == $past(sp_rx_data_i);
    endproperty
    a_store: assert property (p_store) else $error("store mismatch");
    property p_cs;
        !auto_chip_select_out_n_o |-> spi_master_i;
    endproperty
    a_cs: assert property (p_cs) else $error("select low in slave");
    property p_gap;
        sp_byte_done_i && spi_master_i |=> !sp_tx_valid_o [*8];
    endproperty
    a_gap: assert property (p_gap) else $error("gap too short");
    property p_end;
        $fell(transfer_active_o) && $past(sp_byte_done_i, 2) |-> port_event_flag_o;
    endproperty
    a_end: assert property (p_end) else $error("no flag at end");
endmodule : sdc_monitor
`default_nettype wire

/* File: verif/sdc_peer.sv */
// Serial port and SRAM model facing the DMA control
`timescale 1ns/100ps
`default_nettype none
module sdc_peer (
    input wire logic sys_clk_i,
    input var int dly_i,
    input wire logic tx_valid_i,
    input wire sdc_pkg::sdc_mem_s mem_i,
    output logic [7:0] rdata_o,
    output logic done_o,
    output logic [7:0] rx_o
);
    import sdc_pkg::*;
    logic [7:0] mem [4096];
    int nb = 0;
    int wt = 0;
    initial begin
        rdata_o = 8'h00;
        done_o = 1'b0;
        for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5a;
    end
    // Read data valid one cycle only; the lines toggle when nothing is presented
    always @(posedge sys_clk_i) begin
        rdata_o <= mem_i.rd ? mem[mem_i.addr] : ~rdata_o;
        if (mem_i.wr) mem[mem_i.addr] <= mem_i.wdata;
        done_o <= (wt == 1);
        if (wt == 1) nb <= nb + 1;
        if (tx_valid_i) wt <= dly_i;
        else if (wt > 0) wt <= wt - 1;
    end
    assign rx_o = done_o ? 8'(nb) : ~8'(nb);
endmodule : sdc_peer
`default_nettype wire

/* File: verif/test_sdc_top.sv */
// Self-checking bench for the serial DMA control
`timescale 1ns/100ps
`default_nettype none
module test_sdc_top;
    import sdc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    sdc_bus_s bus = '0;
    logic master = 1'b1;
    logic [1:0] div = 2'b00;
    logic [7:0] rdata, txd, rxd, mrd, base;
    logic txv, done, csn, flag, act;
    sdc_mem_s mreq;
    int dly = 6;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int last_done = 0;
    int t;
    logic [15:0] gapv, dones, rises, wrs, fdn;
    logic [7:0] tx_q[$];
    int mn[3] = '{8, 9, 15};
    always #4 sys_clk_i = ~sys_clk_i;
    sdc_top sdc_top_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_bus_i(bus),
        .reg_rdata_o(rdata), .spi_master_i(master), .clk_div_i(div), .sp_tx_valid_o(txv),
        .sp_tx_data_o(txd), .sp_byte_done_i(done), .sp_rx_data_i(rxd), .mem_req_o(mreq),
        .mem_rdata_i(mrd), .auto_chip_select_out_n_o(csn), .port_event_flag_o(flag),
        .transfer_active_o(act));
    sdc_peer sdc_peer_inst (.sys_clk_i(sys_clk_i), .dly_i(dly), .tx_valid_i(txv),
        .mem_i(mreq), .rdata_o(mrd), .done_o(done), .rx_o(rxd));
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (done) last_done <= cyc;
        if (done) dones <= dones + 16'h1;
        if (txv) tx_q.push_back(txd);
        if (txv) gapv <= 16'(cyc - last_done);
        if (mreq.wr) wrs <= wrs + 16'h1;
        if ($rose(csn)) rises <= rises + 16'h1;
        if ($rose(flag)) fdn <= dones;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus <= '{1'b1, 1'b0, a, d};
        @(posedge sys_clk_i);
        bus <= '0;
        @(posedge sys_clk_i);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge sys_clk_i);
        bus <= '0;
        #1;
        chk(16'(rdata), 16'(e));
        @(posedge sys_clk_i);
    endtask : rdc
    task automatic run(input logic [7:0] m, input logic [7:0] gw, input logic [9:0] n);
        wr(12'hf86, gw);
        wr(12'hf84, n[7:0]);
        wr(12'hf85, {6'h00, n[9:8]});
        wr(12'hf8a, 8'h10);
        wr(12'hf8c, 8'h80);
        wr(12'hf8e, 8'h03);
        tx_q = {};
        dones = '0;
        rises = '0;
        wrs = '0;
        fdn = '1;
        base = 8'(sdc_peer_inst.nb);
        wr(12'hf88, m);
    endtask : run
    task automatic fin();
        for (t = 0; t < 5000 && act === 1'b1; t++) @(posedge sys_clk_i);
        chk(16'(act), 16'h0);
        repeat (3) @(posedge sys_clk_i);
    endtask : fin
    function automatic logic [15:0] dec(input int f);
        if (f < 8) return 16'(1 << f);
        if (f > 13) return 16'(1024 << (f - 14));
        return 16'((f - 6) * 128);
    endfunction : dec
    task automatic t_regs();
        rdc(12'hf86, 8'h00);
        rdc(12'hf88, 8'h00);
        rdc(12'hf84, 8'h00);
        rdc(12'hf80, 8'h00);
        wr(12'hf8b, 8'hff);
        rdc(12'hf8b, 8'h0f);
        wr(12'hf8b, 8'h00);
        wr(12'hf80, 8'h55);
        wr(12'hf84, 8'hff);
        wr(12'hf85, 8'h03);
        rdc(12'hf84, 8'hff);
        rdc(12'hf85, 8'h03);
        wr(12'hf88, 8'hc2);
        rdc(12'hf88, 8'hc0);
        wr(12'hf88, 8'h02);
        rdc(12'hf88, 8'h02);
        wr(12'hf88, 8'h00);
    endtask : t_regs
    task automatic t_full();
        run(8'h79, 8'h00, 10'h003);
        fin();
        chk(dones, 16'h4);
        chk(rises, 16'h2);
        chk(fdn, 16'h4);
        for (int i = 0; i < 4; i++) begin
            chk(16'(tx_q[i]), 16'(8'(8'h10 + i) ^ 8'h5a));
            chk(16'(sdc_peer_inst.mem[12'h080 + i]), 16'(8'(base + i + 1)));
        end
        rdc(12'hf84, 8'h00);
        rdc(12'hf85, 8'h00);
        rdc(12'hf88, 8'h78);
        rdc(12'hf8a, 8'h14);
        rdc(12'hf8c, 8'h84);
    endtask : t_full
    task automatic t_cs();
        logic [1:0] cs[3] = '{2'b11, 2'b10, 2'b00};
        logic [15:0] ex[3] = '{16'h1, 16'h4, 16'h0};
        for (int i = 0; i < 3; i++) begin
            run({cs[i], 6'h25}, 8'h00, 10'h003);
            fin();
            chk(rises, ex[i]);
        end
    endtask : t_cs
    task automatic t_gap();
        for (int d = 0; d < 3; d++) begin
            for (int f = 0; f < 17; f++) begin
                div <= 2'(d);
                run(f == 16 ? 8'h27 : 8'h25, f == 16 ? 8'hf0 : 8'(f << 4), 10'h001);
                fin();
                chk(gapv, 16'(mn[d] + 4) + (f == 16 ? 16'h1 : dec(f)));
                chk(16'(gapv >= 16'(mn[d] + 5)), 16'h1);
            end
        end
        div <= 2'b00;
    endtask : t_gap
    task automatic t_dir();
        run(8'h01, 8'h00, 10'h002);
        fin();
        chk(16'(tx_q[0]), 16'h00ff);
        chk(wrs, 16'h3);
        chk(16'(sdc_peer_inst.mem[12'h080]), 16'(8'(base + 3)));
        run(8'h05, 8'h00, 10'h002);
        fin();
        chk(16'(tx_q[2]), 16'h004a);
        chk(wrs, 16'h0);
    endtask : t_dir
    task automatic t_wm();
        logic [7:0] wm[4] = '{8'h04, 8'h07, 8'h01, 8'h05};
        logic [15:0] ex[4] = '{16'h2, 16'h0, 16'h9, 16'h0};
        for (int i = 0; i < 4; i++) begin
            run(8'h09, wm[i], 10'h009);
            fin();
            chk(fdn, ex[i]);
        end
    endtask : t_wm
    task automatic t_abort();
        dly = 40;
        run(8'h39, 8'h00, 10'h003);
        for (t = 0; t < 20 && tx_q.size() == 0; t++) @(posedge sys_clk_i);
        wr(12'hf88, 8'h38);
        chk(16'(act), 16'h0);
        for (t = 0; t < 60 && dones == 16'h0; t++) @(posedge sys_clk_i);
        repeat (4) @(posedge sys_clk_i);
        chk(dones, 16'h1);
        chk(wrs, 16'h0);
        chk(16'(tx_q.size()), 16'h1);
        rdc(12'hf84, 8'h03);
        dly = 6;
    endtask : t_abort
    task automatic t_tmo();
        master <= 1'b0;
        for (int g = 1; g >= 0; g--) begin
            run({6'h00, 1'(g), 1'b1}, 8'h00, 10'h001);
            fin();
            rdc(12'hf8e, {6'h00, 1'(g), 1'b1});
        end
        master <= 1'b1;
    endtask : t_tmo
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (12) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_full();
        t_cs();
        t_gap();
        t_dir();
        t_wm();
        t_abort();
        t_tmo();
        wrap_up();
    end
    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end
endmodule : test_sdc_top
bind sdc_top sdc_monitor sdc_monitor_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .reg_bus_i(reg_bus_i), .spi_master_i(spi_master_i), .sp_tx_valid_o(sp_tx_valid_o),
    .sp_tx_data_o(sp_tx_data_o), .sp_byte_done_i(sp_byte_done_i),
    .sp_rx_data_i(sp_rx_data_i), .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i),
    .auto_chip_select_out_n_o(auto_chip_select_out_n_o),
    .port_event_flag_o(port_event_flag_o), .transfer_active_o(transfer_active_o));
`default_nettype wire
